// ### ddr_pin_pkg.sv
package ddr_pin_pkg;

  localparam int DATA_W = 16;
  localparam int LANES = 2;
  localparam int LANE_W = 8;
  localparam int ADDR_W = 14;
  localparam int BANK_W = 3;
  localparam int WORD_W = DATA_W + LANES;

  // Command codes as {row, column, write} strobes, active low
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_ACTIVATE = 3'h3;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_PRECHARGE = 3'h2;
  localparam logic [2:0] CMD_REFRESH = 3'h1;
  localparam logic [2:0] CMD_LOAD_MODE = 3'h0;

  // Bank select values naming the mode registers
  localparam logic [2:0] MODE_REG_MR = 3'h0;
  localparam logic [2:0] MODE_REG_EMR = 3'h1;
  localparam logic [2:0] MODE_REG_EMR2 = 3'h2;
  localparam logic [2:0] MODE_REG_EMR3 = 3'h3;

  localparam logic [1:0] BURST_LEN = 2'h3;
  localparam logic RST_CLOCK_GATE = 1'b0;
  localparam logic RST_MEMORY_RESET = 1'b1;

  typedef enum logic [1:0] {
    OP_ACTIVATE,
    OP_READ,
    OP_WRITE,
    OP_OTHER
  } cmd_kind_t;

endpackage

// ### cdc_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module cdc_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end

  assign q_o = sync_ff;
endmodule
`default_nettype wire

// ### skid_buf2.sv
`timescale 1ns/1ps
`default_nettype none
module skid_buf2 #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  logic [W-1:0] mem_ff [2];
  logic wr_ptr_ff;
  logic rd_ptr_ff;
  logic [1:0] count_ff;
  logic push;
  logic pop;

  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign in_ready_o = (count_ff != 2'h2);
  assign out_valid_o = (count_ff != 2'h0);
  assign out_data_o = mem_ff[rd_ptr_ff];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_i;
    end
  end
endmodule
`default_nettype wire

// ### ddr_memory_pin_interface.sv
// Notes on behaviour
// RULE1: Bank select names the target bank of activate, read, write, precharge.
// RULE2: On load mode, bank select names MR, EMR, EMR2 or EMR3.
// RULE3: Row and column strobes with other command pins encode the operation.
// RULE4: Memory clock forwarded on true output plus its exact complement.
// RULE5: Clock gate output active high: high enables, low disables memory clock.
// RULE6: Chip select asserted with every command; memory ignores deselected commands.
// RULE7: Per-lane mask high masks write data; sampled both strobe edges.
// RULE8: Strobes driven by device with write data, by memory during reads.
// RULE9: Setting selects single-ended or differential strobes; complements unused single-ended.
// RULE10: Termination control high enables memory termination if memory configured.
// RULE11: Write command output with strobes defines the operation.
// RULE12: Data bus and strobes released during reads, driven only in writes.
`timescale 1ns/1ps
`default_nettype none
module ddr_memory_pin_interface (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic memory_clock_i,
  input wire logic rst_link_n_i,
  // Command request from the controller core (system domain)
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic [2:0] cmd_code_i,
  input wire logic [ddr_pin_pkg::BANK_W-1:0] cmd_bank_i,
  input wire logic [ddr_pin_pkg::ADDR_W-1:0] cmd_addr_i,
  // Write data, one word per burst beat
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire logic [ddr_pin_pkg::DATA_W-1:0] wr_data_i,
  input wire logic [ddr_pin_pkg::LANES-1:0] wr_mask_i,
  // Read data returned to the core
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic [ddr_pin_pkg::DATA_W-1:0] rd_data_o,
  // Static controls
  input wire logic clock_gate_en_i,
  input wire logic termination_en_i,
  input wire logic strobe_diff_i,
  input wire logic memory_reset_i,
  // Memory pins
  output logic memory_clock_out_o,
  output logic memory_clock_out_n_o,
  output logic memory_clock_gate_o,
  output logic chip_select_out_n_o,
  output logic row_strobe_out_n_o,
  output logic column_strobe_out_n_o,
  output logic write_command_out_n_o,
  output logic [ddr_pin_pkg::BANK_W-1:0] bank_select_o,
  output logic [ddr_pin_pkg::ADDR_W-1:0] mem_address_bus_o,
  output logic termination_control_o,
  output logic memory_reset_out_n_o,
  input wire logic [ddr_pin_pkg::DATA_W-1:0] memory_data_bus_i,
  output logic [ddr_pin_pkg::DATA_W-1:0] memory_data_bus_o,
  output logic [ddr_pin_pkg::DATA_W-1:0] memory_data_bus_oe_o,
  output logic lower_byte_mask_o,
  output logic upper_byte_mask_o,
  input wire logic lower_byte_strobe_i,
  output logic lower_byte_strobe_o,
  output logic lower_byte_strobe_oe_o,
  output logic lower_byte_strobe_n_o,
  output logic lower_byte_strobe_n_oe_o,
  input wire logic upper_byte_strobe_i,
  output logic upper_byte_strobe_o,
  output logic upper_byte_strobe_oe_o,
  output logic upper_byte_strobe_n_o,
  output logic upper_byte_strobe_n_oe_o
);
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CMD,
    ST_WRITE,
    ST_READ
  } link_state_t;
  localparam int CMD_W = 3 + ddr_pin_pkg::BANK_W + ddr_pin_pkg::ADDR_W;
  localparam int RD_W = ddr_pin_pkg::DATA_W;
  // Command and write words cross by a 4-phase req/ack handshake: slow, but the link
  // clock is unrelated and a command word is rare compared to data.
  logic [CMD_W-1:0] cmd_hold_ff;
  logic cmd_req_ff;
  logic cmd_busy_ff;
  logic cmd_ack_sys;
  logic cmd_ready_ff;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_hold_ff <= '0;
      cmd_req_ff <= 1'b0;
      cmd_busy_ff <= 1'b0;
      cmd_ready_ff <= 1'b0;
    end else begin
      cmd_ready_ff <= !cmd_busy_ff && !cmd_ack_sys && !(cmd_valid_i && cmd_ready_ff);
      if (cmd_valid_i && cmd_ready_ff) begin
        cmd_hold_ff <= {cmd_code_i, cmd_bank_i, cmd_addr_i};
        cmd_req_ff <= 1'b1;
        cmd_busy_ff <= 1'b1;
      end else if (cmd_req_ff && cmd_ack_sys) begin
        cmd_req_ff <= 1'b0;
      end else if (!cmd_req_ff && !cmd_ack_sys) begin
        cmd_busy_ff <= 1'b0;
      end
    end
  end
  assign cmd_ready_o = cmd_ready_ff;
  // Write data buffer on the system side; the link drains it
  logic wbuf_valid;
  logic wbuf_pop;
  logic [ddr_pin_pkg::WORD_W-1:0] wbuf_data;
  logic [ddr_pin_pkg::WORD_W-1:0] whold_ff;
  logic wreq_ff;
  logic wack_sys;
  skid_buf2 #(
    .W(ddr_pin_pkg::WORD_W)
  ) u_wr_buf (
    .clk_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(wr_valid_i),
    .in_ready_o(wr_ready_o),
    .in_data_i({wr_mask_i, wr_data_i}),
    .out_valid_o(wbuf_valid),
    .out_ready_i(wbuf_pop),
    .out_data_o(wbuf_data)
  );
  assign wbuf_pop = wbuf_valid && !wreq_ff && !wack_sys;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wreq_ff <= 1'b0;
      whold_ff <= '0;
    end else if (wbuf_pop) begin
      wreq_ff <= 1'b1;
      whold_ff <= wbuf_data;
    end else if (wack_sys) begin
      wreq_ff <= 1'b0;
    end
  end
  // Read data returns through a toggle and a two-entry buffer
  logic rd_tog_sys;
  logic rd_tog_seen_ff;
  logic rbuf_ready;
  logic rbuf_valid;
  logic [RD_W-1:0] rbuf_data;
  logic rd_valid_ff;
  logic [RD_W-1:0] rd_data_ff;
  logic [RD_W-1:0] rd_hold_link_ff;
  logic rbuf_push;
  // Read word is loaded with the toggle and settles while the toggle passes the two synchroniser flops before it is sampled
  assign rbuf_push = (rd_tog_sys != rd_tog_seen_ff);
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_tog_seen_ff <= 1'b0;
    end else if (rbuf_push && rbuf_ready) begin
      rd_tog_seen_ff <= rd_tog_sys;
    end
  end
  skid_buf2 #(
    .W(RD_W)
  ) u_rd_buf (
    .clk_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(rbuf_push),
    .in_ready_o(rbuf_ready),
    .in_data_i(rd_hold_link_ff),
    .out_valid_o(rbuf_valid),
    .out_ready_i(!rd_valid_ff || rd_ready_i),
    .out_data_o(rbuf_data)
  );
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_valid_ff <= 1'b0;
      rd_data_ff <= '0;
    end else if (!rd_valid_ff || rd_ready_i) begin
      rd_valid_ff <= rbuf_valid;
      rd_data_ff <= rbuf_data;
    end
  end
  assign rd_valid_o = rd_valid_ff;
  assign rd_data_o = rd_data_ff;
  logic cmd_req_link;
  logic wreq_link;
  logic [3:0] ctl_link;
  logic cmd_ack_ff;
  logic wack_ff;
  logic rd_tog_ff;
  logic rd_seen_link;
  // Consumed-toggle comes back through flops so read pacing stays in one domain
  cdc_sync2 #(.W(7)) u_to_link (
    .clk_i(memory_clock_i),
    .rst_n_i(rst_link_n_i),
    .d_i({cmd_req_ff, wreq_ff, rd_tog_seen_ff, clock_gate_en_i, termination_en_i, strobe_diff_i, memory_reset_i}),
    .q_o({cmd_req_link, wreq_link, rd_seen_link, ctl_link})
  );
  cdc_sync2 #(.W(3)) u_to_sys (
    .clk_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .d_i({cmd_ack_ff, wack_ff, rd_tog_ff}),
    .q_o({cmd_ack_sys, wack_sys, rd_tog_sys})
  );
  link_state_t state_ff;
  logic [1:0] beat_ff;
  logic [2:0] code_ff;
  logic cs_n_ff;
  logic ras_n_ff;
  logic cas_n_ff;
  logic we_n_ff;
  logic [ddr_pin_pkg::BANK_W-1:0] bank_ff;
  logic [ddr_pin_pkg::ADDR_W-1:0] addr_ff;
  logic [ddr_pin_pkg::DATA_W-1:0] dq_ff;
  logic dq_oe_ff;
  logic [ddr_pin_pkg::LANES-1:0] dm_ff;
  logic dqs_ff;
  logic gate_ff;
  logic odt_ff;
  logic diff_ff;
  logic reset_n_ff;
  logic [1:0] lane_din_meta_ff;
  logic [1:0] lane_din_ff;
  logic [ddr_pin_pkg::DATA_W-1:0] dq_meta_ff;
  logic [ddr_pin_pkg::DATA_W-1:0] dq_in_ff;
  always_ff @(posedge memory_clock_i or negedge rst_link_n_i) begin
    if (!rst_link_n_i) begin
      gate_ff <= ddr_pin_pkg::RST_CLOCK_GATE;
      odt_ff <= 1'b0;
      diff_ff <= 1'b0;
      reset_n_ff <= ~ddr_pin_pkg::RST_MEMORY_RESET;
    end else begin
      gate_ff <= ctl_link[3]; // RULE5
      odt_ff <= ctl_link[2]; // RULE10
      diff_ff <= ctl_link[1]; // RULE9
      reset_n_ff <= ~ctl_link[0];
    end
  end
  // Read strobe and data pins sampled through two flops each
  always_ff @(posedge memory_clock_i or negedge rst_link_n_i) begin
    if (!rst_link_n_i) begin
      lane_din_meta_ff <= '0;
      lane_din_ff <= '0;
      dq_meta_ff <= '0;
      dq_in_ff <= '0;
    end else begin
      lane_din_meta_ff <= {upper_byte_strobe_i, lower_byte_strobe_i}; // RULE8
      lane_din_ff <= lane_din_meta_ff;
      dq_meta_ff <= memory_data_bus_i;
      dq_in_ff <= dq_meta_ff;
    end
  end
  always_ff @(posedge memory_clock_i or negedge rst_link_n_i) begin
    if (!rst_link_n_i) begin
      state_ff <= ST_IDLE;
      beat_ff <= 2'h0;
      code_ff <= ddr_pin_pkg::CMD_NOP;
      cmd_ack_ff <= 1'b0;
      wack_ff <= 1'b0;
      rd_tog_ff <= 1'b0;
      rd_hold_link_ff <= '0;
      cs_n_ff <= 1'b1;
      ras_n_ff <= 1'b1;
      cas_n_ff <= 1'b1;
      we_n_ff <= 1'b1;
      bank_ff <= '0;
      addr_ff <= '0;
      dq_ff <= '0;
      dq_oe_ff <= 1'b0;
      dm_ff <= '0;
      dqs_ff <= 1'b0;
    end else begin
      cs_n_ff <= 1'b1;
      {ras_n_ff, cas_n_ff, we_n_ff} <= ddr_pin_pkg::CMD_NOP;
      dqs_ff <= 1'b0;
      unique case (state_ff)
        ST_IDLE: begin
          dq_oe_ff <= 1'b0; // RULE12
          if (cmd_req_link && !cmd_ack_ff) begin
            cs_n_ff <= 1'b0; // RULE6
            {ras_n_ff, cas_n_ff, we_n_ff} <= cmd_hold_ff[CMD_W-1 -: 3]; // RULE3 RULE11
            // Bank field carries either the bank or the mode register id
            bank_ff <= cmd_hold_ff[ddr_pin_pkg::ADDR_W +: ddr_pin_pkg::BANK_W]; // RULE1 RULE2
            addr_ff <= cmd_hold_ff[ddr_pin_pkg::ADDR_W-1:0];
            code_ff <= cmd_hold_ff[CMD_W-1 -: 3];
            cmd_ack_ff <= 1'b1;
            state_ff <= ST_CMD;
          end
        end
        ST_CMD: begin
          beat_ff <= 2'h0;
          if (!cmd_req_link) begin
            cmd_ack_ff <= 1'b0;
            if (code_ff == ddr_pin_pkg::CMD_WRITE) begin
              state_ff <= ST_WRITE;
            end else if (code_ff == ddr_pin_pkg::CMD_READ) begin
              state_ff <= ST_READ;
            end else begin
              state_ff <= ST_IDLE;
            end
          end
        end
        ST_WRITE: begin
          // Strobe pulses only while a write beat is present; the bus stays driven until the last beat's ack drops
          if (wreq_link && !wack_ff) begin
            dq_ff <= whold_ff[ddr_pin_pkg::DATA_W-1:0];
            dm_ff <= whold_ff[ddr_pin_pkg::WORD_W-1 -: ddr_pin_pkg::LANES]; // RULE7
            dq_oe_ff <= 1'b1; // RULE12
            dqs_ff <= 1'b1; // RULE8
            wack_ff <= 1'b1;
          end else if (!wreq_link && wack_ff) begin
            wack_ff <= 1'b0;
            beat_ff <= beat_ff + 2'h1;
            if (beat_ff == ddr_pin_pkg::BURST_LEN) begin
              dq_oe_ff <= 1'b0;
              state_ff <= ST_IDLE;
            end
          end
        end
        ST_READ: begin
          dq_oe_ff <= 1'b0; // RULE12
          // One word per beat, paced by the toggle return and the memory's strobe
          if (rd_tog_ff == rd_seen_link && lane_din_ff != 2'h0) begin // RULE8
            rd_hold_link_ff <= dq_in_ff;
            rd_tog_ff <= ~rd_tog_ff;
            beat_ff <= beat_ff + 2'h1;
            if (beat_ff == ddr_pin_pkg::BURST_LEN) begin
              state_ff <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end
  // Forwarded clock from a flop pair so both outputs come from registers
  logic clk_fwd_ff;
  logic clk_fwd_n_ff;
  always_ff @(negedge memory_clock_i or negedge rst_link_n_i) begin
    if (!rst_link_n_i) begin
      clk_fwd_ff <= 1'b0;
      clk_fwd_n_ff <= 1'b1;
    end else begin
      clk_fwd_ff <= ~clk_fwd_ff; // RULE4
      clk_fwd_n_ff <= clk_fwd_ff;
    end
  end
  assign memory_clock_out_o = clk_fwd_ff;
  assign memory_clock_out_n_o = clk_fwd_n_ff;
  assign memory_clock_gate_o = gate_ff;
  assign chip_select_out_n_o = cs_n_ff;
  assign row_strobe_out_n_o = ras_n_ff;
  assign column_strobe_out_n_o = cas_n_ff;
  assign write_command_out_n_o = we_n_ff;
  assign bank_select_o = bank_ff;
  assign mem_address_bus_o = addr_ff;
  assign termination_control_o = odt_ff;
  assign memory_reset_out_n_o = reset_n_ff;
  assign memory_data_bus_o = dq_ff;
  assign memory_data_bus_oe_o = {ddr_pin_pkg::DATA_W{dq_oe_ff}};
  assign lower_byte_mask_o = dm_ff[0];
  assign upper_byte_mask_o = dm_ff[1];
  assign lower_byte_strobe_o = dqs_ff;
  assign upper_byte_strobe_o = dqs_ff;
  assign lower_byte_strobe_oe_o = dq_oe_ff;
  assign upper_byte_strobe_oe_o = dq_oe_ff;
  assign lower_byte_strobe_n_o = ~dqs_ff;
  assign upper_byte_strobe_n_o = ~dqs_ff;
  // Complement strobes left floating in single-ended mode
  assign lower_byte_strobe_n_oe_o = dq_oe_ff & diff_ff;
  assign upper_byte_strobe_n_oe_o = dq_oe_ff & diff_ff;
endmodule
`default_nettype wire

// ### ddr_pin_props.sv
`timescale 1ns/1ps
`default_nettype none
module ddr_pin_props (
  input wire logic memory_clock_i,
  input wire logic rst_link_n_i,
  input wire logic clock_gate_en_i,
  input wire logic termination_en_i,
  input wire logic strobe_diff_i,
  input wire logic memory_clock_out_o,
  input wire logic memory_clock_out_n_o,
  input wire logic memory_clock_gate_o,
  input wire logic chip_select_out_n_o,
  input wire logic row_strobe_out_n_o,
  input wire logic column_strobe_out_n_o,
  input wire logic write_command_out_n_o,
  input wire logic [ddr_pin_pkg::BANK_W-1:0] bank_select_o,
  input wire logic termination_control_o,
  input wire logic [ddr_pin_pkg::DATA_W-1:0] memory_data_bus_oe_o,
  input wire logic lower_byte_strobe_oe_o,
  input wire logic upper_byte_strobe_oe_o,
  input wire logic lower_byte_strobe_n_oe_o,
  input wire logic upper_byte_strobe_n_oe_o
);
  default clocking cb @(posedge memory_clock_i); endclocking
  default disable iff (!rst_link_n_i);
  logic [2:0] cmd;
  assign cmd = {row_strobe_out_n_o, column_strobe_out_n_o, write_command_out_n_o};

  clk_comp_a: assert property (memory_clock_out_n_o == !memory_clock_out_o)
    else $error("clock complement mismatch");
  gate_on_a: assert property (clock_gate_en_i [*6] |-> memory_clock_gate_o)
    else $error("clock gate not raised");
  gate_off_a: assert property (!clock_gate_en_i [*6] |-> !memory_clock_gate_o)
    else $error("clock gate not lowered");
  odt_on_a: assert property (termination_en_i [*6] |-> termination_control_o)
    else $error("termination not driven");
  cs_gate_a: assert property (chip_select_out_n_o |-> cmd == ddr_pin_pkg::CMD_NOP)
    else $error("command without chip select");
  cs_pulse_a: assert property (!chip_select_out_n_o |=> chip_select_out_n_o [*3])
    else $error("commands back to back");
  bank_hold_a: assert property (!chip_select_out_n_o |=> $stable(bank_select_o) [*2])
    else $error("bank select moved after command");
  strobe_data_a: assert property (|memory_data_bus_oe_o |-> lower_byte_strobe_oe_o && upper_byte_strobe_oe_o)
    else $error("data driven without strobes");
  read_release_a: assert property (!chip_select_out_n_o && cmd == ddr_pin_pkg::CMD_READ
    |=> (memory_data_bus_oe_o == 16'h0) [*6])
    else $error("data bus driven during read");
  single_end_a: assert property (!strobe_diff_i [*6] |-> !lower_byte_strobe_n_oe_o && !upper_byte_strobe_n_oe_o)
    else $error("complement strobe driven single-ended");

  cover property (!chip_select_out_n_o && cmd == ddr_pin_pkg::CMD_WRITE);
  cover property (!chip_select_out_n_o && cmd == ddr_pin_pkg::CMD_READ);
  cover property (!chip_select_out_n_o && cmd == ddr_pin_pkg::CMD_LOAD_MODE);
endmodule

bind ddr_memory_pin_interface ddr_pin_props props_u (
  .memory_clock_i(memory_clock_i), .rst_link_n_i(rst_link_n_i), .clock_gate_en_i(clock_gate_en_i),
  .termination_en_i(termination_en_i), .strobe_diff_i(strobe_diff_i), .memory_clock_out_o(memory_clock_out_o),
  .memory_clock_out_n_o(memory_clock_out_n_o), .memory_clock_gate_o(memory_clock_gate_o),
  .chip_select_out_n_o(chip_select_out_n_o), .row_strobe_out_n_o(row_strobe_out_n_o),
  .column_strobe_out_n_o(column_strobe_out_n_o), .write_command_out_n_o(write_command_out_n_o),
  .bank_select_o(bank_select_o), .termination_control_o(termination_control_o),
  .memory_data_bus_oe_o(memory_data_bus_oe_o), .lower_byte_strobe_oe_o(lower_byte_strobe_oe_o),
  .upper_byte_strobe_oe_o(upper_byte_strobe_oe_o), .lower_byte_strobe_n_oe_o(lower_byte_strobe_n_oe_o),
  .upper_byte_strobe_n_oe_o(upper_byte_strobe_n_oe_o)
);
`default_nettype wire

// ### mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  input wire logic clk_i,
  input wire logic cs_n_i,
  input wire logic [2:0] cmd_i,
  input wire logic [2:0] bank_i,
  input wire logic [13:0] addr_i,
  input wire logic [15:0] dq_i,
  input wire logic [15:0] dq_oe_i,
  input wire logic [1:0] dm_i,
  input wire logic dqs_i,
  input wire logic dqs_oe_i,
  output logic [15:0] dq_o,
  output logic dqs_o
);
  logic [2:0] last_cmd = 3'h0;
  logic [2:0] last_bank = 3'h0;
  logic [13:0] last_addr = 14'h0;
  logic [15:0] mem_word = 16'h0;
  logic [15:0] rd_word = 16'h0;
  int n_cmd = 0;
  int n_wr = 0;
  int rd_left = 0;
  initial dqs_o = 1'b0;
  // Released lines show the inverse, never a stale level
  assign dq_o = (rd_left > 0) ? rd_word : ~rd_word;
  always @(posedge clk_i) begin
    // Strobe runs only while read data stands, idles low otherwise
    dqs_o <= (rd_left > 0) ? !dqs_o : 1'b0;
    if (rd_left > 0) rd_left <= rd_left - 1;
    if (!cs_n_i) begin
      last_cmd <= cmd_i;
      last_bank <= bank_i;
      last_addr <= addr_i;
      n_cmd <= n_cmd + 1;
      if (cmd_i == ddr_pin_pkg::CMD_READ) begin
        rd_word <= 16'h5a00 ^ {2'h0, addr_i};
        rd_left <= 64;
      end
    end
    if (dqs_oe_i && dqs_i && dq_oe_i == 16'hffff) begin
      for (int l = 0; l < 2; l++) begin
        if (!dm_i[l]) mem_word[l*8 +: 8] <= dq_i[l*8 +: 8];
      end
      n_wr <= n_wr + 1;
    end
  end
endmodule
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys_i, rst_n_i, memory_clock_i, rst_link_n_i, cmd_valid_i, wr_valid_i, rd_ready_i;
  logic clock_gate_en_i, termination_en_i, strobe_diff_i, memory_reset_i, cmd_ready_o, wr_ready_o, rd_valid_o;
  logic ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, odt, rst_out_n, ldm, udm, m_dqs;
  logic ldqs, ldqs_oe, ldqs_n, ldqs_n_oe, udqs, udqs_oe, udqs_n, udqs_n_oe;
  logic [2:0] cmd_code_i, cmd_bank_i, ba;
  logic [13:0] cmd_addr_i, addr;
  logic [15:0] wr_data_i, rd_data_o, dq_o, dq_oe, m_dq, dq_in;
  logic [1:0] wr_mask_i;
  int mismatches = 0;
  int n_checks = 0;
  int n_diff = 0;
  assign dq_in = (dq_oe & dq_o) | (~dq_oe & m_dq);
  // Beats sent as true differential pairs on both lanes
  always @(posedge memory_clock_i) begin
    if (ldqs_oe && ldqs && ldqs_n_oe && ldqs_n === 1'b0 && udqs_oe && udqs && udqs_n_oe && udqs_n === 1'b0) begin
      n_diff <= n_diff + 1;
    end
  end

  ddr_memory_pin_interface dut_u (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .memory_clock_i(memory_clock_i), .rst_link_n_i(rst_link_n_i),
    .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_code_i(cmd_code_i), .cmd_bank_i(cmd_bank_i),
    .cmd_addr_i(cmd_addr_i), .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o), .wr_data_i(wr_data_i),
    .wr_mask_i(wr_mask_i), .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i), .rd_data_o(rd_data_o),
    .clock_gate_en_i(clock_gate_en_i), .termination_en_i(termination_en_i), .strobe_diff_i(strobe_diff_i),
    .memory_reset_i(memory_reset_i), .memory_clock_out_o(ck), .memory_clock_out_n_o(ck_n),
    .memory_clock_gate_o(cke), .chip_select_out_n_o(cs_n), .row_strobe_out_n_o(ras_n),
    .column_strobe_out_n_o(cas_n), .write_command_out_n_o(we_n), .bank_select_o(ba), .mem_address_bus_o(addr),
    .termination_control_o(odt), .memory_reset_out_n_o(rst_out_n), .memory_data_bus_i(dq_in),
    .memory_data_bus_o(dq_o), .memory_data_bus_oe_o(dq_oe), .lower_byte_mask_o(ldm), .upper_byte_mask_o(udm),
    .lower_byte_strobe_i(ldqs_oe ? ldqs : m_dqs), .lower_byte_strobe_o(ldqs), .lower_byte_strobe_oe_o(ldqs_oe),
    .lower_byte_strobe_n_o(ldqs_n), .lower_byte_strobe_n_oe_o(ldqs_n_oe), .upper_byte_strobe_i(udqs_oe ? udqs : m_dqs),
    .upper_byte_strobe_o(udqs), .upper_byte_strobe_oe_o(udqs_oe), .upper_byte_strobe_n_o(udqs_n),
    .upper_byte_strobe_n_oe_o(udqs_n_oe));

  mem_model mem_u (.clk_i(memory_clock_i), .cs_n_i(cs_n), .cmd_i({ras_n, cas_n, we_n}), .bank_i(ba),
    .addr_i(addr), .dq_i(dq_o), .dq_oe_i(dq_oe), .dm_i({udm, ldm}), .dqs_i(ldqs), .dqs_oe_i(ldqs_oe),
    .dq_o(m_dq), .dqs_o(m_dqs));

  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    memory_clock_i = 1'b0;
    #3.3;
    forever #7.5 memory_clock_i = ~memory_clock_i;
  end

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // Bounded waits: a hang shows up as later mismatches, not a stall
  task idle;
    int k;
    k = 0;
    while (cmd_ready_o !== 1'b1 && k < 300) begin
      @(posedge clk_sys_i);
      #1;
      k++;
    end
    if (k >= 300) mismatches++;
  endtask
  task issue(input logic [2:0] c, input logic [2:0] b, input logic [13:0] a);
    cmd_code_i = c;
    cmd_bank_i = b;
    cmd_addr_i = a;
    cmd_valid_i = 1'b1;
    idle;
    @(posedge clk_sys_i);
    #1;
    cmd_valid_i = 1'b0;
  endtask

  task t_static;
    for (int v = 0; v < 2; v++) begin
      clock_gate_en_i = v[0];
      termination_en_i = v[0];
      memory_reset_i = !v[0];
      tick(10);
      chk("clock_gate", {15'h0, v[0]}, {15'h0, cke});
      chk("termination", {15'h0, v[0]}, {15'h0, odt});
      chk("memory_reset", {15'h0, v[0]}, {15'h0, rst_out_n});
      chk("clock_pair", {15'h0, ~ck}, {15'h0, ck_n});
    end
  endtask
  task t_cmds;
    logic [2:0] cs [7];
    logic [2:0] bs [7];
    int n0;
    cs = '{ddr_pin_pkg::CMD_ACTIVATE, ddr_pin_pkg::CMD_PRECHARGE, ddr_pin_pkg::CMD_REFRESH,
      ddr_pin_pkg::CMD_LOAD_MODE, ddr_pin_pkg::CMD_LOAD_MODE, ddr_pin_pkg::CMD_LOAD_MODE, ddr_pin_pkg::CMD_LOAD_MODE};
    bs = '{3'h6, 3'h7, 3'h0, ddr_pin_pkg::MODE_REG_MR, ddr_pin_pkg::MODE_REG_EMR, ddr_pin_pkg::MODE_REG_EMR2,
      ddr_pin_pkg::MODE_REG_EMR3};
    for (int i = 0; i < 7; i++) begin
      n0 = mem_u.n_cmd;
      issue(cs[i], bs[i], 14'h2a5 + 14'(i));
      idle;
      chk("command", {13'h0, cs[i]}, {13'h0, mem_u.last_cmd});
      chk("bank", {13'h0, bs[i]}, {13'h0, mem_u.last_bank});
      chk("address", 16'h2a5 + 16'(i), {2'h0, mem_u.last_addr});
      chk("cmd_count", 16'(n0 + 1), 16'(mem_u.n_cmd));
    end
  endtask
  task t_write;
    logic [15:0] w [4];
    logic [1:0] m [4];
    int n0;
    int n1;
    int k;
    w = '{16'h1111, 16'h2222, 16'h3333, 16'h4444};
    m = '{2'h0, 2'h2, 2'h1, 2'h3};
    for (int d = 1; d >= 0; d--) begin
      strobe_diff_i = d[0];
      tick(6);
      n0 = mem_u.n_wr;
      n1 = n_diff;
      issue(ddr_pin_pkg::CMD_WRITE, 3'h2, 14'h0040);
      for (int i = 0; i < 4; i++) begin
        wr_data_i = w[i];
        wr_mask_i = m[i];
        wr_valid_i = 1'b1;
        k = 0;
        while (wr_ready_o !== 1'b1 && k < 300) begin
          @(posedge clk_sys_i);
          #1;
          k++;
        end
        @(posedge clk_sys_i);
        #1;
      end
      wr_valid_i = 1'b0;
      idle;
      tick(60);
      chk("write_beats", 16'(n0 + 4), 16'(mem_u.n_wr));
      chk("masked_word", 16'h3322, mem_u.mem_word);
      chk("diff_strobes", 16'(n1 + 4 * d), 16'(n_diff));
    end
  endtask
  task t_read;
    int k;
    issue(ddr_pin_pkg::CMD_READ, 3'h5, 14'h0123);
    // Core stalls long enough to fill the return buffer
    tick(40);
    rd_ready_i = 1'b1;
    for (int i = 0; i < 4; i++) begin
      k = 0;
      while (rd_valid_o !== 1'b1 && k < 300) begin
        @(posedge clk_sys_i);
        #1;
        k++;
      end
      chk("read_word", 16'h5a00 ^ 16'h0123, rd_data_o);
      @(posedge clk_sys_i);
      #1;
    end
    rd_ready_i = 1'b0;
    idle;
    tick(20);
    chk("read_extra", 16'h0, {15'h0, rd_valid_o});
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    {rst_n_i, rst_link_n_i, cmd_valid_i, wr_valid_i, rd_ready_i} = 5'h0;
    {clock_gate_en_i, termination_en_i, strobe_diff_i, memory_reset_i} = 4'h1;
    {cmd_code_i, cmd_bank_i, cmd_addr_i, wr_data_i, wr_mask_i} = '0;
    tick(5);
    chk("cs_in_reset", 16'h1, {15'h0, cs_n});
    chk("oe_in_reset", 16'h0, dq_oe);
    chk("mem_reset_in_reset", 16'h0, {15'h0, rst_out_n});
    tick(1);
    rst_n_i = 1'b1;
    rst_link_n_i = 1'b1;
    memory_reset_i = 1'b0;
    tick(3);
    t_static;
    t_cmds;
    t_write;
    t_read;
    close_out;
  end
  initial begin
    #200000;
    mismatches++;
    close_out;
  end
endmodule
`default_nettype wire
